// ---- spisp_regs.svh ----
// Purpose: Shared constants of the clock-stop serial port block.
// Assumes: Included by its bare name from the package and the modules.
// Notes: Holds definitions only.
`ifndef SPISP_REGS_SVH
`define SPISP_REGS_SVH

// ----------------------------------------------------------------------
// Sample-rate generator settings
// ----------------------------------------------------------------------
`define SPISP_DIV_W 8
`define SPISP_SRC_CPU 1'b1
`define SPISP_SRC_EXT 1'b0
`define SPISP_SLAVE_DIV 8'h01
`define SPISP_CNT_W 9
`define SPISP_PHASE_MIN 9'h001

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SPISP_WORD_W 8
`define SPISP_CLK_PERIOD_NS 8

`endif

// ---- spisp_pkg.sv ----
// Purpose: Types shared by the clock-stop serial port modules.
// Assumes: spisp_regs.svh is on the include path.
// Notes: Constants live in the header; this package holds types only.
`include "spisp_regs.svh"

package spisp_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [`SPISP_DIV_W-1:0] spisp_div_t;
  typedef logic [`SPISP_CNT_W-1:0] spisp_cnt_t;

  typedef enum logic [1:0] {
    SPISP_IDLE,
    SPISP_SHIFT,
    SPISP_HOLD
  } spisp_state_t;

endpackage

// ---- spisp_clk_if.sv ----
// Purpose: Connection between the transfer core and the sample-rate generator.
// Assumes: Both ends run on clk_sys.
// Notes: Edge pulses are one clk_sys cycle wide.
`timescale 1ns/1ps

interface spisp_clk_if;
  import spisp_pkg::*;

  logic source_select;
  logic ext_clock;
  spisp_div_t divider;
  logic run;
  logic tick;
  logic gen_level;
  logic rise;
  logic fall;
  spisp_cnt_t low_ticks;
  spisp_cnt_t period_ticks;

  modport gen (
    input source_select, ext_clock, divider, run,
    output tick, gen_level, rise, fall, low_ticks, period_ticks
  );
  modport core (
    output source_select, ext_clock, divider, run,
    input tick, gen_level, rise, fall, low_ticks, period_ticks
  );
endinterface

// ---- spisp_srg.sv ----
// Purpose: Sample-rate generator producing the generated bit clock.
// Assumes: The external clock input is synchronous to clk_sys.
// Notes: The clock level is held low whenever run is low.
`timescale 1ns/1ps
`include "spisp_regs.svh"

module spisp_srg
  import spisp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  spisp_clk_if.gen cif
);

  spisp_cnt_t hi_ticks;
  spisp_cnt_t lo_ticks;
  spisp_cnt_t cnt_q, cnt_d;
  logic pre_q, pre_d;
  logic ext_q, ext_d;
  logic lvl_q, lvl_d;
  logic tick;

  // ----------------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------------
  // Divider zero would give an empty low phase, so each phase is at least one tick.
  always_comb begin
    if (cif.divider[0]) begin
      hi_ticks = spisp_cnt_t'((`SPISP_CNT_W'(cif.divider) + `SPISP_PHASE_MIN) >> 1);
      lo_ticks = hi_ticks;
    end else begin
      hi_ticks = spisp_cnt_t'((`SPISP_CNT_W'(cif.divider) >> 1) + `SPISP_PHASE_MIN);
      lo_ticks = spisp_cnt_t'(`SPISP_CNT_W'(cif.divider) >> 1);
    end
    if (lo_ticks == '0) begin
      lo_ticks = `SPISP_PHASE_MIN;
    end
  end

  assign cif.low_ticks = lo_ticks;
  assign cif.period_ticks = spisp_cnt_t'(hi_ticks + lo_ticks);

  // ----------------------------------------------------------------------
  // Input tick and phase counter
  // ----------------------------------------------------------------------
  // The CPU source ticks every second cycle; the external source ticks on its rising edge.
  always_comb begin
    pre_d = ~pre_q;
    ext_d = cif.ext_clock;
    tick = (cif.source_select == `SPISP_SRC_CPU) ? pre_q : (cif.ext_clock & ~ext_q);
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    cif.rise = 1'b0;
    cif.fall = 1'b0;
    if (!cif.run) begin
      cnt_d = '0;
      lvl_d = 1'b0;
    end else if (tick) begin
      if (!lvl_q && (cnt_q + `SPISP_PHASE_MIN == lo_ticks)) begin
        cnt_d = '0;
        lvl_d = 1'b1;
        cif.rise = 1'b1;
      end else if (lvl_q && (cnt_q + `SPISP_PHASE_MIN == hi_ticks)) begin
        cnt_d = '0;
        lvl_d = 1'b0;
        cif.fall = 1'b1;
      end else begin
        cnt_d = spisp_cnt_t'(cnt_q + `SPISP_PHASE_MIN);
      end
    end
  end

  assign cif.tick = tick;
  assign cif.gen_level = lvl_q;

  // Registers of the generator.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= 1'b0;
      ext_q <= 1'b0;
      cnt_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ext_q <= ext_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  cpu_tick_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cif.source_select && $stable(cif.source_select) && tick) |->
      ##1 (!tick || !cif.source_select) ##1 (tick || !cif.source_select))
    else $error("CPU source tick is not every second cycle");

  high_phase_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cif.fall) |-> (cnt_q + `SPISP_PHASE_MIN == hi_ticks) && lvl_q)
    else $error("High phase ended at the wrong tick count");

  stopped_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cif.run) |=> !lvl_q)
    else $error("Generated clock not low while stopped");

endmodule

// ---- spisp_core.sv ----
// Purpose: Clock-stop SPI transfer engine, mode 10b with clock polarity 0, master or slave.
// Assumes: All pin inputs are synchronous to clk_sys; configuration is static during a frame.
// Notes: Words are sent and received most significant bit first.
`timescale 1ns/1ps
`include "spisp_regs.svh"

// Function
// - The generator input is two CPU cycles when the source select is 1, else the external clock.
// - The bit clock period is one plus the divider, or two for divider zero, times the generator input period.
// - The high phase is divider/2+1 ticks for even dividers, zero included, and (divider+1)/2 for odd ones.
// - The low phase is divider/2 ticks for even dividers, (divider+1)/2 for odd ones and one tick for zero.
// - As master the transmit clock and sync are outputs and the receive clock and sync are inputs.
// - In slave mode the generator runs from the CPU source with divider 1.
// - With sync polarity 1 the master drives its frame sync inverted as an active-low select.
// - As slave the active-low select arriving on the sync pins is inverted before use.
// - The select goes low before the first rising bit clock edge, which starts the transfer.
// - Receive data is sampled on the falling edge of the bit clock in both roles.
// - Transmit data changes to each new bit after the rising edge of the bit clock.
// - As master the select is asserted about one low phase before the first rising edge.
// - As master the select stays low about one full period after the last falling edge.
// - As master the data output is released about one low phase after the last falling edge.
// - As slave the data output is released when the select input goes high.
// - As slave the first data bit is driven once the select input goes low, before any clock edge.
module spisp_core
  import spisp_pkg::*;
#(
  parameter int WORD_W = `SPISP_WORD_W
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic role_master,
  input wire logic srg_source_select,
  input wire spisp_div_t srg_divider,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic ext_clock_in,
  input wire logic start,
  input wire logic [WORD_W-1:0] tx_word,
  output logic busy,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_valid,
  output logic tx_clock_direction,
  output logic tx_sync_direction,
  output logic rx_clock_direction,
  output logic rx_sync_direction,
  output logic generated_clock,
  input wire logic tx_bit_clock_in,
  output logic tx_bit_clock_out,
  output logic tx_bit_clock_oe,
  input wire logic tx_frame_sync_in,
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe,
  input wire logic rx_frame_sync_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe
);

  localparam int BIT_W = $clog2(WORD_W + 1);

  spisp_clk_if cif ();

  spisp_state_t state_q, state_d;
  logic [WORD_W-1:0] tx_sh_q, tx_sh_d;
  logic [WORD_W-1:0] rx_sh_q, rx_sh_d;
  logic [WORD_W-1:0] rx_word_q, rx_word_d;
  logic [BIT_W-1:0] bits_q, bits_d;
  spisp_cnt_t hold_q, hold_d;
  logic fs_q, fs_d;
  logic first_q, first_d;
  logic dout_q, dout_d;
  logic oe_q, oe_d;
  logic valid_q, valid_d;
  logic ck_q, ck_d;
  logic sel_q, sel_d;
  logic slave_sel;
  logic rx_sel;
  logic bit_rise;
  logic bit_fall;
  logic last_fall;

  // ----------------------------------------------------------------------
  // Sample-rate generator
  // ----------------------------------------------------------------------
  // A slave ignores the programmed divider so its internal timing is fixed.
  always_comb begin
    cif.source_select = role_master ? srg_source_select : `SPISP_SRC_CPU;
    cif.divider = role_master ? srg_divider : `SPISP_SLAVE_DIV;
    cif.ext_clock = ext_clock_in;
    cif.run = role_master ? (state_q == SPISP_SHIFT) : 1'b1;
  end

  spisp_srg u_srg (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cif(cif)
  );

  // ----------------------------------------------------------------------
  // Pin directions and select decoding
  // ----------------------------------------------------------------------
  // Receive clock and sync are always inputs; the transmit pair follows the role.
  always_comb begin
    tx_clock_direction = role_master;
    tx_sync_direction = role_master;
    rx_clock_direction = 1'b0;
    rx_sync_direction = 1'b0;
    slave_sel = tx_sync_polarity ? ~tx_frame_sync_in : tx_frame_sync_in;
    rx_sel = rx_sync_polarity ? ~rx_frame_sync_in : rx_frame_sync_in;
    tx_frame_sync_out = tx_sync_polarity ? ~fs_q : fs_q;
    tx_frame_sync_oe = role_master;
    tx_bit_clock_out = role_master & cif.gen_level;
    tx_bit_clock_oe = role_master;
    generated_clock = cif.gen_level;
  end

  // Bit clock edges come from the generator as master and from the pin as slave.
  assign bit_rise = role_master ? cif.rise : (tx_bit_clock_in & ~ck_q);
  assign bit_fall = role_master ? cif.fall : (~tx_bit_clock_in & ck_q);
  assign last_fall = bit_fall && (bits_q == BIT_W'(WORD_W - 1));

  // ----------------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------------
  // The first rising edge only launches the data already loaded; later ones shift.
  always_comb begin
    state_d = state_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    rx_word_d = rx_word_q;
    bits_d = bits_q;
    hold_d = hold_q;
    fs_d = fs_q;
    first_d = first_q;
    dout_d = dout_q;
    oe_d = oe_q;
    valid_d = 1'b0;
    ck_d = tx_bit_clock_in;
    sel_d = slave_sel;
    if (role_master) begin
      unique case (state_q)
        SPISP_IDLE: begin
          oe_d = 1'b0;
          if (start) begin
            state_d = SPISP_SHIFT;
            fs_d = 1'b1;
            tx_sh_d = tx_word;
            bits_d = '0;
            first_d = 1'b1;
          end
        end
        SPISP_SHIFT: begin
          if (bit_rise) begin
            dout_d = first_q ? tx_sh_q[WORD_W-1] : tx_sh_q[WORD_W-2];
            if (!first_q) begin
              tx_sh_d = {tx_sh_q[WORD_W-2:0], 1'b0};
            end
            oe_d = 1'b1;
            first_d = 1'b0;
          end
          if (bit_fall) begin
            rx_sh_d = {rx_sh_q[WORD_W-2:0], serial_data_in};
            bits_d = BIT_W'(bits_q + 1'b1);
            if (last_fall) begin
              state_d = SPISP_HOLD;
              hold_d = '0;
            end
          end
        end
        SPISP_HOLD: begin
          if (cif.tick) begin
            hold_d = spisp_cnt_t'(hold_q + `SPISP_PHASE_MIN);
            if (hold_q + `SPISP_PHASE_MIN == cif.low_ticks) begin
              oe_d = 1'b0;
            end
            if (hold_q + `SPISP_PHASE_MIN == cif.period_ticks) begin
              fs_d = 1'b0;
              state_d = SPISP_IDLE;
              rx_word_d = rx_sh_q;
              valid_d = 1'b1;
            end
          end
        end
      endcase
    end else begin
      state_d = SPISP_IDLE;
      fs_d = 1'b0;
      if (!slave_sel) begin
        oe_d = 1'b0;
        bits_d = '0;
      end else if (!sel_q) begin
        tx_sh_d = tx_word;
        dout_d = tx_word[WORD_W-1];
        oe_d = 1'b1;
        first_d = 1'b1;
        bits_d = '0;
      end else begin
        if (bit_rise) begin
          if (!first_q) begin
            dout_d = tx_sh_q[WORD_W-2];
            tx_sh_d = {tx_sh_q[WORD_W-2:0], 1'b0};
          end
          first_d = 1'b0;
        end
        if (bit_fall && rx_sel) begin
          rx_sh_d = {rx_sh_q[WORD_W-2:0], serial_data_in};
          bits_d = BIT_W'(bits_q + 1'b1);
          if (last_fall) begin
            rx_word_d = {rx_sh_q[WORD_W-2:0], serial_data_in};
            valid_d = 1'b1;
            bits_d = '0;
            first_d = 1'b1;
          end
        end
      end
    end
  end

  // Registers of the transfer engine.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SPISP_IDLE;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      rx_word_q <= '0;
      bits_q <= '0;
      hold_q <= '0;
      fs_q <= 1'b0;
      first_q <= 1'b0;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      valid_q <= 1'b0;
      ck_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_word_q <= rx_word_d;
      bits_q <= bits_d;
      hold_q <= hold_d;
      fs_q <= fs_d;
      first_q <= first_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      valid_q <= valid_d;
      ck_q <= ck_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------------------------------------
  // User side outputs
  // ----------------------------------------------------------------------
  // Busy covers the whole master frame, including the closing hold time.
  always_comb begin
    busy = role_master ? (state_q != SPISP_IDLE) : sel_q;
    rx_word = rx_word_q;
    rx_valid = valid_q;
    serial_data_out = dout_q;
    serial_data_oe = oe_q;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  master_dirs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    role_master |-> tx_clock_direction && tx_sync_direction && !rx_clock_direction && !rx_sync_direction)
    else $error("Master pin directions wrong");

  sync_inverted_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && tx_sync_polarity && state_q == SPISP_SHIFT) |-> !tx_frame_sync_out)
    else $error("Master select not driven low during transfer");

  select_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && cif.rise && first_q) |-> fs_q && state_q == SPISP_SHIFT && !cif.gen_level)
    else $error("First rising edge without select asserted");

  sample_on_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && state_q == SPISP_SHIFT && cif.fall) |=> rx_sh_q[0] == $past(serial_data_in))
    else $error("Receive bit not taken on falling edge");

  data_on_rise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && state_q == SPISP_SHIFT && !cif.rise) |=> $stable(serial_data_out))
    else $error("Data changed away from a rising edge");

  idle_clock_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && state_q == SPISP_IDLE && $past(state_q) == SPISP_IDLE) |-> !tx_bit_clock_out && !fs_q)
    else $error("Master clock or select active while idle");

  hold_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (role_master && state_q == SPISP_HOLD && hold_q < cif.low_ticks) |-> fs_q && !cif.gen_level)
    else $error("Select released or clock running during hold");

  slave_first_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!role_master && slave_sel && !sel_q) |=> serial_data_oe && serial_data_out == $past(tx_word[WORD_W-1]))
    else $error("Slave first bit not driven after select");

  slave_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!role_master && !slave_sel) |=> !serial_data_oe)
    else $error("Slave still drives data with select high");

  slave_clock_cfg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!role_master) |-> cif.source_select && cif.divider == `SPISP_SLAVE_DIV)
    else $error("Slave generator not at fixed rate");

endmodule

// ---- spisp_peer.sv ----
// Purpose: Behavioural far-side SPI device for the clock-stop port bench.
// Assumes: Pin levels are resolved by the bench and sampled on clk_sys.
// Notes: Acts as slave while peer_master is low, as master through run_master.
`timescale 1ns/1ps

module spisp_peer (
  input wire logic clk_sys,
  input wire logic peer_master,
  input wire logic dut_clk,
  input wire logic dut_sel,
  input wire logic dut_line,
  input wire logic [7:0] word,
  output logic peer_clk,
  output logic peer_sel_n,
  output logic peer_data,
  output logic [7:0] got
);
  logic clk_q;
  logic sel_q;
  logic [7:0] sh_q;
  int rises;

  // Idle pins: clock low, select released.
  initial begin
    peer_clk = 1'b0;
    peer_sel_n = 1'b1;
    peer_data = 1'b0;
    got = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Slave side
  // ----------------------------------------------------------------------
  // An unselected data line toggles every cycle, so a stale bit never passes.
  always @(posedge clk_sys) begin
    if (!peer_master && dut_sel) begin
      if (!sel_q) begin
        sh_q <= word;
        peer_data <= word[7];
        rises = 0;
      end else if (dut_clk && !clk_q) begin
        rises++;
        if (rises > 1) begin
          sh_q <= sh_q << 1;
          peer_data <= sh_q[6];
        end
      end else if (!dut_clk && clk_q) begin
        got <= {got[6:0], dut_line};
      end
    end else if (peer_sel_n) begin
      peer_data <= ~peer_data;
    end
    clk_q <= dut_clk;
    sel_q <= dut_sel;
  end

  // ----------------------------------------------------------------------
  // Master side
  // ----------------------------------------------------------------------
  // One word, MSB first; the clock stands low outside the frame.
  task automatic run_master(input int hp);
    logic [7:0] sh;
    sh = word;
    @(negedge clk_sys);
    peer_sel_n = 1'b0;
    peer_data = sh[7];
    repeat (hp) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      peer_clk = 1'b1;
      @(negedge clk_sys);
      if (i > 0) begin
        sh = sh << 1;
        peer_data = sh[7];
      end
      repeat (hp - 1) @(negedge clk_sys);
      peer_clk = 1'b0;
      got = {got[6:0], dut_line};
      repeat (hp) @(negedge clk_sys);
    end
    peer_sel_n = 1'b1;
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the clock-stop SPI port in both roles.
// Assumes: spisp_peer stands on the far side of the pins.
// Notes: Edge timings are measured on the resolved pins each clk_sys cycle.
`timescale 1ns/1ps

module testbench
  import spisp_pkg::*;
();
  logic clk_sys, sys_rst, role_master, srg_source_select, tx_sync_polarity, rx_sync_polarity;
  logic ext_clock_in, start, busy, rx_valid, generated_clock, line_q, ck_q, fsa_q, oe_q, g_q;
  logic tx_clock_direction, tx_sync_direction, rx_clock_direction, rx_sync_direction;
  logic tx_bit_clock_out, tx_bit_clock_oe, tx_frame_sync_out, tx_frame_sync_oe;
  logic serial_data_out, serial_data_oe, peer_clk, peer_sel_n, peer_data;
  logic [7:0] tx_word, pword, rx_word, got;
  spisp_div_t srg_divider;
  int miscompares, num_checks, cyc, n_rise, stray, rxv_n, hi_min, lo_min, hi_max, lo_max;
  int t_act, t_inact, t_r1, t_rise, t_lf, t_oe0, t_g, g_per, ext_n;
  int corner[5] = '{0, 1, 2, 3, 255};
  wire ck_pin = tx_bit_clock_oe ? tx_bit_clock_out : peer_clk;
  wire fs_pin = tx_frame_sync_oe ? tx_frame_sync_out : peer_sel_n;
  wire fs_act = fs_pin ^ tx_sync_polarity;
  wire dline = serial_data_oe ? serial_data_out : ~line_q;

  spisp_core i_spisp_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .role_master(role_master),
    .srg_source_select(srg_source_select), .srg_divider(srg_divider), .tx_sync_polarity(tx_sync_polarity),
    .rx_sync_polarity(rx_sync_polarity), .ext_clock_in(ext_clock_in), .start(start), .tx_word(tx_word),
    .busy(busy), .rx_word(rx_word), .rx_valid(rx_valid), .tx_clock_direction(tx_clock_direction),
    .tx_sync_direction(tx_sync_direction), .rx_clock_direction(rx_clock_direction),
    .rx_sync_direction(rx_sync_direction), .generated_clock(generated_clock), .tx_bit_clock_in(ck_pin),
    .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe), .tx_frame_sync_in(fs_pin),
    .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe), .rx_frame_sync_in(peer_sel_n),
    .serial_data_in(peer_data), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

  spisp_peer i_spisp_peer (.clk_sys(clk_sys), .peer_master(~role_master), .dut_clk(ck_pin),
    .dut_sel(role_master & fs_act), .dut_line(dline), .word(pword), .peer_clk(peer_clk),
    .peer_sel_n(peer_sel_n), .peer_data(peer_data), .got(got));

  // ----------------------------------------------------------------------
  // Clocks and pin monitor
  // ----------------------------------------------------------------------
  // System clock, 8 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // External generator clock with a six-cycle period.
  always @(negedge clk_sys) begin
    ext_n++;
    if (ext_n % 3 == 0) ext_clock_in = ~ext_clock_in;
  end

  // Records pulse widths and edge times; also cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    line_q <= dline;
    if (ck_pin && !ck_q) begin
      if (!fs_act) stray++;
      if (n_rise == 0) t_r1 = cyc;
      else begin
        if (cyc - t_lf < lo_min) lo_min = cyc - t_lf;
        if (cyc - t_lf > lo_max) lo_max = cyc - t_lf;
      end
      n_rise++;
      t_rise = cyc;
    end
    if (!ck_pin && ck_q) begin
      if (cyc - t_rise < hi_min) hi_min = cyc - t_rise;
      if (cyc - t_rise > hi_max) hi_max = cyc - t_rise;
      t_lf = cyc;
    end
    if (fs_act && !fsa_q) t_act = cyc;
    if (!fs_act && fsa_q) t_inact = cyc;
    if (!serial_data_oe && oe_q) t_oe0 = cyc;
    if (generated_clock && !g_q) begin
      g_per = cyc - t_g;
      t_g = cyc;
    end
    if (rx_valid) rxv_n++;
    ck_q = ck_pin;
    fsa_q = fs_act;
    oe_q = serial_data_oe;
    g_q = generated_clock;
    if (cyc == 40000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  function automatic int hi_t(input int d);
    return d == 0 ? 1 : (d % 2 == 0 ? d / 2 + 1 : (d + 1) / 2);
  endfunction

  // A zero divider is widened to one tick, since the formula leaves no low phase.
  function automatic int lo_t(input int d);
    return d == 0 ? 1 : (d % 2 == 0 ? d / 2 : (d + 1) / 2);
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Edge delays are tick-aligned, so one input period of slack is allowed.
  task automatic near(input string nm, input int exp, input int seen, input int tol);
    num_checks++;
    if (seen < exp - tol || seen > exp + tol) begin
      miscompares++;
      $display("FAIL %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic dirs(input logic m);
    chk("tx_clk_dir", m, tx_clock_direction);
    chk("tx_sync_dir", m, tx_sync_direction);
    chk("rx_clk_dir", 0, rx_clock_direction);
    chk("rx_sync_dir", 0, rx_sync_direction);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // One master word with the given divider, source and select polarity.
  task automatic mframe(input int d, input logic src, input logic pol);
    int s, h, l, k;
    s = src ? 2 : 6;
    h = hi_t(d);
    l = lo_t(d);
    @(negedge clk_sys);
    role_master = 1'b1;
    srg_source_select = src;
    srg_divider = d[7:0];
    tx_sync_polarity = pol;
    rx_sync_polarity = pol;
    tx_word = 8'($urandom);
    pword = 8'($urandom);
    repeat (2) @(negedge clk_sys);
    chk("fs_idle", pol, fs_pin);
    n_rise = 0;
    rxv_n = 0;
    hi_min = 99999;
    lo_min = 99999;
    hi_max = 0;
    lo_max = 0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 9000) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (2) @(negedge clk_sys);
    chk("rises", 8, n_rise);
    chk("hi_width", h * s, hi_min);
    chk("lo_width", l * s, lo_min);
    chk("period", (d == 0 ? 2 : d + 1) * s, hi_max + lo_max);
    near("sel_lead", l * s, t_r1 - t_act, s);
    near("sel_hold", (h + l) * s, t_inact - t_lf, s);
    near("dx_release", l * s, t_oe0 - t_lf, s);
    chk("rx_word", pword, rx_word);
    chk("rx_valid", 1, rxv_n);
    chk("peer_got", tx_word, got);
  endtask

  // One slave word; the generator settings given must be overridden.
  task automatic sframe();
    @(negedge clk_sys);
    role_master = 1'b0;
    srg_source_select = 1'b0;
    srg_divider = 8'h07;
    tx_sync_polarity = 1'b1;
    rx_sync_polarity = 1'b1;
    tx_word = 8'($urandom);
    pword = 8'($urandom);
    rxv_n = 0;
    repeat (12) @(negedge clk_sys);
    chk("gen_period", 4, g_per);
    chk("idle_busy", 0, busy);
    dirs(1'b0);
    fork
      i_spisp_peer.run_master(6);
      begin
        @(posedge peer_clk);
        chk("s_oe", 1, serial_data_oe);
        chk("s_msb", tx_word[7], serial_data_out);
      end
    join
    repeat (3) @(negedge clk_sys);
    chk("s_release", 0, serial_data_oe);
    chk("s_rx", pword, rx_word);
    chk("s_valid", 1, rxv_n);
    chk("s_tx", tx_word, got);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reset, corner dividers, external source, random frames, then slave words.
  initial begin
    role_master = 1'b1;
    srg_source_select = 1'b1;
    srg_divider = 8'h01;
    tx_sync_polarity = 1'b1;
    rx_sync_polarity = 1'b1;
    ext_clock_in = 1'b0;
    start = 1'b0;
    tx_word = 8'h00;
    pword = 8'h00;
    line_q = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    void'($urandom(16541));
    chk("rst_oe", 0, serial_data_oe);
    chk("rst_clk", 0, tx_bit_clock_out);
    dirs(1'b1);
    foreach (corner[i]) mframe(corner[i], 1'b1, 1'b1);
    mframe(2, 1'b0, 1'b1);
    mframe(5, 1'b0, 1'b0);
    repeat (6) mframe($urandom % 12, 1'($urandom), 1'($urandom));
    sframe();
    sframe();
    chk("stray_rises", 0, stray);
    conclude();
  end
endmodule
